// *** verif/dm_link_checker.sv ***
// assertions on the direct-master window link
`timescale 1ns/1ps
module dm_link_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link signals
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic acc_valid,
   input wire logic [31:0] acc_addr,
   input wire logic acc_done,
   input wire logic dm_hit,
   input wire dm_window_pkg::dm_kind_t dm_kind,
   input wire logic [31:0] pci_addr,
   input wire logic lock_active
);
   logic [31:0] mask_q, ctl_q, cfg_q;
   logic [31:0] m;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // shadow copies of written range, control and config registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mask_q <= 32'h0;
         ctl_q <= 32'h0;
         cfg_q <= 32'h0;
      end else begin
         mask_q <= (reg_wr && reg_addr == 8'h9C) ? reg_wdata : mask_q;
         ctl_q <= (reg_wr && reg_addr == 8'hA8) ? reg_wdata : ctl_q;
         cfg_q <= (reg_wr && reg_addr == 8'hAC) ? reg_wdata : cfg_q;
      end
   end

   // selected upper address bits
   assign m = {mask_q[31:16], 16'h0};

   a_reg_ack_timing: assert property ((reg_wr || reg_rd) |=> reg_ack)
      else $error("register access not acknowledged");
   a_low_half_zero: assert property (reg_ack && $past(reg_rd)
      && $past(reg_addr) inside {8'h9C, 8'hA0, 8'hA4} |-> reg_rdata[15:0] == 16'h0)
      else $error("low half of window register not zero");
   a_hit_cause: assert property ($rose(dm_hit) |-> $past(acc_valid))
      else $error("hit without access start");
   a_hit_end: assert property (dm_hit && acc_done |=> !dm_hit)
      else $error("hit outlives access");
   a_mem_gate: assert property (dm_hit && dm_kind == dm_window_pkg::KIND_MEM |-> ctl_q[0])
      else $error("memory decode while disabled");
   a_io_gate: assert property (dm_hit && dm_kind != dm_window_pkg::KIND_MEM |-> ctl_q[1])
      else $error("io decode while disabled");
   a_remap_bits: assert property ($rose(dm_hit) && dm_kind != dm_window_pkg::KIND_CFG
      |-> pci_addr == (($past(acc_addr) & ~m) | (ctl_q & m)))
      else $error("remapped address wrong");
   a_cfg_form: assert property ($rose(dm_hit) && dm_kind == dm_window_pkg::KIND_CFG
      |-> cfg_q[31] && pci_addr == {8'h00, cfg_q[23:0]})
      else $error("config address wrong");
   a_lock_gate: assert property ($rose(lock_active) |-> ctl_q[2])
      else $error("lock taken while disabled");
   a_addr_held: assert property (dm_hit && $past(dm_hit) |-> $stable(pci_addr))
      else $error("address moved during access");

   // main scenarios reached
   c_mem: cover property ($rose(dm_hit) && dm_kind == dm_window_pkg::KIND_MEM);
   c_cfg: cover property ($rose(dm_hit) && dm_kind == dm_window_pkg::KIND_CFG);
   c_lock: cover property ($rose(lock_active));
endmodule

// *** verif/tb.sv ***
// self-checking bench for both ends of the direct-master window link
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'h0, rst_n_i = 1'h0, cmd_valid_i = 1'h0, cmd_io_i = 1'h0;
   logic cmd_write_i = 1'h0, cmd_lock_i = 1'h0, acc_end_i = 1'h0, pci_rd_word_i = 1'h0;
   logic rd_fifo_full_i = 1'h0, wr_pop_i = 1'h0, pf_valid_i = 1'h0;
   logic [1:0] cmd_op_i = 2'h0;
   logic [3:0] cmd_len_i = 4'h0;
   logic [31:0] cmd_addr_i = 32'h0, cmd_data_i = 32'h0;
   logic cmd_ready_o, rsp_valid_o, rsp_refused_o, pci_prefetch_o, pci_release_o, pci_irdy_n_o;
   logic [31:0] rsp_data_o;
   logic [35:0] expq [$];
   logic [35:0] e;
   logic [29:0] rnd;
   logic [7:0] wa [6] = '{8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0};
   logic [31:0] wd [6] = '{32'hC000_FFFF, 32'h4000_1234, 32'h8000_0000, 32'h8000_FF02,
      32'h0, 32'hFFFF_FFFF};
   logic [31:0] rv [6] = '{32'hC000_0000, 32'h4000_0000, 32'h8000_0000, 32'h8000_0002,
      32'h0, 32'h0};
   int failures = 0, checks = 0, seed = 31818;
   localparam logic [35:0] WOK = 36'h8_0000_0000, RF = 36'hC_0000_0000;

   dm_link_if u_dm_link_if ();
   dm_bridge_end u_dm_bridge_end (.clk_i, .rst_n_i, .link(u_dm_link_if), .pci_rd_word_i,
      .rd_fifo_full_i, .wr_pop_i, .pci_prefetch_o, .pci_release_o, .pci_irdy_n_o);
   dm_master_end #(.PLATFORM_FORCE(1'h0)) u_dm_master_end (.clk_i, .rst_n_i,
      .link(u_dm_link_if), .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_data_i, .cmd_io_i,
      .cmd_write_i, .cmd_lock_i, .cmd_len_i, .acc_end_i, .cmd_ready_o, .rsp_valid_o,
      .rsp_refused_o, .rsp_data_o);
   // second master with platform forcing on, no bridge behind it: only its writes are seen
   dm_link_if u_pf_link_if ();
   dm_master_end #(.PLATFORM_FORCE(1'h1)) u_dm_master_end_pf (.clk_i, .rst_n_i,
      .link(u_pf_link_if), .cmd_valid_i(pf_valid_i), .cmd_op_i, .cmd_addr_i, .cmd_data_i,
      .cmd_io_i, .cmd_write_i, .cmd_lock_i, .cmd_len_i, .acc_end_i, .cmd_ready_o(),
      .rsp_valid_o(), .rsp_refused_o(), .rsp_data_o());
   assign {u_pf_link_if.reg_ack, u_pf_link_if.reg_rdata, u_pf_link_if.dm_hit,
      u_pf_link_if.pci_addr} = 66'h0;
   dm_link_checker u_dm_link_checker (.clk_i, .rst_n_i, .reg_wr(u_dm_link_if.reg_wr),
      .reg_rd(u_dm_link_if.reg_rd), .reg_addr(u_dm_link_if.reg_addr),
      .reg_wdata(u_dm_link_if.reg_wdata), .reg_rdata(u_dm_link_if.reg_rdata),
      .reg_ack(u_dm_link_if.reg_ack), .acc_valid(u_dm_link_if.acc_valid),
      .acc_addr(u_dm_link_if.acc_addr), .acc_done(u_dm_link_if.acc_done),
      .dm_hit(u_dm_link_if.dm_hit), .dm_kind(u_dm_link_if.dm_kind),
      .pci_addr(u_dm_link_if.pci_addr), .lock_active(u_dm_link_if.lock_active));

   // 50 ns clock
   always #25 clk_i = ~clk_i;

   // compare one value and count it
   task automatic check(input string nm, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   // print verdict and end the run
   task automatic report_and_stop();
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // note expectation, then hand one command to the master end; f is {io, write, lock}
   task automatic cmd(input logic [1:0] op, input logic [31:0] a, d, input logic [2:0] f,
      input logic [3:0] len, input logic [35:0] x);
      int n;
      n = 0;
      expq.push_back(x);
      @(negedge clk_i);
      {cmd_valid_i, cmd_op_i, cmd_addr_i, cmd_data_i} = {1'h1, op, a, d};
      {cmd_io_i, cmd_write_i, cmd_lock_i, cmd_len_i} = {f, len};
      while (cmd_ready_o !== 1'h1 && n < 200) begin
         n++;
         @(negedge clk_i);
      end
      @(negedge clk_i);
      cmd_valid_i = 1'h0;
   endtask

   // start an access and check its decode
   task automatic acc(input logic [31:0] a, input logic [2:0] f, input logic [3:0] len,
      input dm_window_pkg::dm_kind_t k, input logic [31:0] pa);
      cmd(2'h2, a, 32'h0, f, len, (k == dm_window_pkg::KIND_NONE) ? RF : {4'hA, pa});
      repeat (3) @(negedge clk_i);
      check("dm_hit", k != dm_window_pkg::KIND_NONE, u_dm_link_if.dm_hit);
      if (k != dm_window_pkg::KIND_NONE) begin
         check("dm_kind", k, u_dm_link_if.dm_kind);
         check("pci_addr", pa, u_dm_link_if.pci_addr);
      end
   endtask

   // end the running access
   task automatic end_acc();
      @(negedge clk_i);
      acc_end_i = 1'h1;
      @(negedge clk_i);
      acc_end_i = 1'h0;
      repeat (3) @(negedge clk_i);
   endtask

   // pulse the fetched-longword strobe n times
   task automatic fetch(input int n);
      repeat (n) begin
         @(negedge clk_i);
         pci_rd_word_i = 1'h1;
         @(negedge clk_i);
         pci_rd_word_i = 1'h0;
      end
   endtask

   // compare each master response with the oldest note
   always @(negedge clk_i) begin
      if (rsp_valid_o === 1'h1) begin
         e = (expq.size() > 0) ? expq.pop_front() : 36'hF_FFFF_FFFF;
         if (e[35]) check("rsp_refused", e[34], rsp_refused_o);
         if (e[33]) check("rsp_data", e[31:0], rsp_data_o);
      end
   end

   // hang guard
   initial begin
      #(50 * 20000);
      failures++;
      report_and_stop();
   end

   // main sequence
   initial begin
      rnd = 30'($random(seed));
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'h1;
      {pf_valid_i, cmd_op_i, cmd_addr_i, cmd_data_i} = {1'h1, 2'h0, 32'hA8, 32'h8000_00F9};
      @(negedge clk_i);
      pf_valid_i = 1'h0;
      check("forced_ctl", 32'h8000_0015, u_pf_link_if.reg_wdata);
      foreach (wa[i]) cmd(2'h1, {24'h0, wa[i]}, 32'h0, 3'h0, 4'h0, {4'hA, 32'h0});
      cmd(2'h2, 32'h8000_0000, 32'h0, 3'h4, 4'h1, RF);
      foreach (wa[i]) begin
         cmd(2'h0, {24'h0, wa[i]}, wd[i], 3'h0, 4'h0, WOK);
         cmd(2'h1, {24'h0, wa[i]}, 32'h0, 3'h0, 4'h0, {4'hA, rv[i]});
      end
      cmd(2'h0, 32'hA4, 32'h4000_0000, 3'h0, 4'h0, RF);
      acc({2'h1, rnd}, 3'h0, 4'h1, dm_window_pkg::KIND_NONE, 32'h0);
      end_acc();
      cmd(2'h0, 32'hA8, 32'h8000_0007, 3'h0, 4'h0, WOK);
      acc({2'h1, rnd}, 3'h1, 4'h1, dm_window_pkg::KIND_MEM, {2'h2, rnd});
      check("lock_active", 32'h1, u_dm_link_if.lock_active);
      fetch(5);
      check("prefetch", 32'h1, pci_prefetch_o);
      rd_fifo_full_i = 1'h1;
      @(negedge clk_i);
      check("release", 32'h1, pci_release_o);
      rd_fifo_full_i = 1'h0;
      end_acc();
      rnd = 30'($random(seed));
      acc({2'h2, rnd}, 3'h4, 4'h1, dm_window_pkg::KIND_IO, {2'h2, rnd});
      end_acc();
      cmd(2'h0, 32'hAC, 32'h8012_3456, 3'h0, 4'h0, WOK);
      cmd(2'h1, 32'hAC, 32'h0, 3'h0, 4'h0, {4'hA, 32'h8012_3456});
      acc({2'h2, rnd}, 3'h4, 4'h1, dm_window_pkg::KIND_CFG, 32'h0012_3456);
      end_acc();
      cmd(2'h0, 32'hA8, 32'h8000_0051, 3'h0, 4'h0, WOK);
      acc({2'h1, rnd}, 3'h1, 4'h1, dm_window_pkg::KIND_MEM, {2'h2, rnd});
      check("lock_active", 32'h0, u_dm_link_if.lock_active);
      rd_fifo_full_i = 1'h1;
      @(negedge clk_i);
      check("release", 32'h0, pci_release_o);
      check("irdy_n", 32'h1, pci_irdy_n_o);
      rd_fifo_full_i = 1'h0;
      end_acc();
      for (int i = 0; i < 3; i++) begin
         acc({2'h1, rnd}, 3'h2, 4'h1, dm_window_pkg::KIND_MEM, {2'h2, rnd});
         end_acc();
         check("almost_full_n", i < 2, u_dm_link_if.write_fifo_almost_full_n);
      end
      wr_pop_i = 1'h1;
      @(negedge clk_i);
      wr_pop_i = 1'h0;
      repeat (2) @(negedge clk_i);
      check("almost_full_n", 32'h1, u_dm_link_if.write_fifo_almost_full_n);
      cmd(2'h0, 32'hA8, 32'h8000_0009, 3'h0, 4'h0, WOK);
      cmd(2'h2, {2'h1, rnd}, 32'h0, 3'h0, 4'h5, RF);
      acc({2'h1, rnd}, 3'h0, 4'h4, dm_window_pkg::KIND_MEM, {2'h2, rnd});
      fetch(3);
      check("prefetch", 32'h1, pci_prefetch_o);
      fetch(1);
      check("prefetch", 32'h0, pci_prefetch_o);
      end_acc();
      check("leftover", 32'h0, expq.size());
      report_and_stop();
   end
endmodule

// *** verilog/dm_bridge_end.sv ***
// bridge end: direct-master window registers, decode, remap, write FIFO almost-full flag and PCI read controls
`timescale 1ns/1ps
`include "dm_window_map.svh"
module dm_bridge_end (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link to local master
   dm_link_if.bridge link,
   // PCI side
   input wire logic pci_rd_word_i,
   input wire logic rd_fifo_full_i,
   input wire logic wr_pop_i,
   output logic pci_prefetch_o,
   output logic pci_release_o,
   output logic pci_irdy_n_o
);
   dm_window_pkg::bridge_state_t q, d;
   logic mem_hit, io_hit;
   logic [15:0] mem_hi, io_hi;
   logic push, pop;
   logic [2:0] thr;

   // --------------------------------------------------------------------
   // window decoders
   // --------------------------------------------------------------------
   dm_window_decode #(
      .W(16)
   ) u_mem_win (
      .enable_i(q.ctl[`DM_CTL_MEM_EN]),
      .mask_i(q.range_mask),
      .base_i(q.mem_base),
      .remap_i(q.remap_hi),
      .addr_hi_i(link.acc_addr[`DM_HI_MSB:`DM_HI_LSB]),
      .hit_o(mem_hit),
      .mapped_hi_o(mem_hi)
   );

   dm_window_decode #(
      .W(16)
   ) u_io_win (
      .enable_i(q.ctl[`DM_CTL_IO_EN]),
      .mask_i(q.range_mask),
      .base_i(q.io_base),
      .remap_i(q.remap_hi),
      .addr_hi_i(link.acc_addr[`DM_HI_MSB:`DM_HI_LSB]),
      .hit_o(io_hit),
      .mapped_hi_o(io_hi)
   );

   // --------------------------------------------------------------------
   // write FIFO occupancy events
   // --------------------------------------------------------------------
   assign push = link.acc_valid && !q.active && link.acc_write && (mem_hit || io_hit)
                 && (q.wcount != `DM_WFIFO_DEPTH);
   assign pop = wr_pop_i && (q.wcount != 4'h0);
   assign thr = q.ctl[`DM_CTL_THR_MSB:`DM_CTL_THR_LSB];

   // --------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------
   always_comb begin
      d = q;
      d.ack = 1'b0;
      // register writes
      if (link.reg_wr) begin
         d.ack = 1'b1;
         case (link.reg_addr)
            `DM_OFS_RANGE_MASK: d.range_mask = link.reg_wdata[`DM_HI_MSB:`DM_HI_LSB];
            `DM_OFS_MEM_BASE: d.mem_base = link.reg_wdata[`DM_HI_MSB:`DM_HI_LSB];
            `DM_OFS_IO_BASE: d.io_base = link.reg_wdata[`DM_HI_MSB:`DM_HI_LSB];
            `DM_OFS_REMAP_CTL: begin
               d.remap_hi = link.reg_wdata[`DM_HI_MSB:`DM_HI_LSB];
               d.ctl = link.reg_wdata[7:0];
            end
            `DM_OFS_CFG_ADDR: d.cfg_addr = link.reg_wdata;
            default: d.ack = 1'b1; // unmapped write is dropped
         endcase
      end else if (link.reg_rd) begin
         d.ack = 1'b1;
         case (link.reg_addr)
            `DM_OFS_RANGE_MASK: d.rdata = {q.range_mask, 16'h0000};
            `DM_OFS_MEM_BASE: d.rdata = {q.mem_base, 16'h0000};
            `DM_OFS_IO_BASE: d.rdata = {q.io_base, 16'h0000};
            `DM_OFS_REMAP_CTL: d.rdata = {q.remap_hi, 8'h00, q.ctl};
            `DM_OFS_CFG_ADDR: d.rdata = q.cfg_addr;
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      // start of a direct-master access; memory window wins an overlap
      if (link.acc_valid && !q.active && (mem_hit || io_hit)) begin
         d.active = 1'b1;
         d.is_write = link.acc_write;
         d.fetched = 3'h0;
         d.lock = link.acc_lock && q.ctl[`DM_CTL_LOCK_EN];
         if (mem_hit) begin
            d.kind = dm_window_pkg::KIND_MEM;
            d.pci_addr = {mem_hi, link.acc_addr[15:0]};
         end else if (q.cfg_addr[`DM_CFG_ENABLE]) begin
            d.kind = dm_window_pkg::KIND_CFG;
            d.pci_addr = {8'h00, q.cfg_addr[`DM_CFG_BUS_MSB:`DM_CFG_REG_LSB],
                          q.cfg_addr[`DM_CFG_TYPE_MSB:0]};
         end else begin
            d.kind = dm_window_pkg::KIND_IO;
            d.pci_addr = {io_hi, link.acc_addr[15:0]};
         end
      end else if (link.acc_done && q.active) begin
         d.active = 1'b0; // prefetch stops here
         d.kind = dm_window_pkg::KIND_NONE;
         d.lock = 1'b0;
      end
      // longwords fetched from PCI this access
      if (q.active && !q.is_write && pci_rd_word_i && (q.fetched != `DM_PREFETCH_LIMIT)) begin
         d.fetched = q.fetched + 3'h1;
      end
      // write FIFO occupancy and almost-full flag
      if (push && !pop) begin
         d.wcount = q.wcount + 4'h1;
      end else if (pop && !push) begin
         d.wcount = q.wcount - 4'h1;
      end
      d.af_n = !(d.wcount > {1'b0, thr});
   end

   // --------------------------------------------------------------------
   // state register
   // --------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.range_mask <= `DM_RST_HI;
         q.mem_base <= `DM_RST_HI;
         q.io_base <= `DM_RST_HI;
         q.remap_hi <= `DM_RST_HI;
         q.ctl <= `DM_RST_CTL;
         q.cfg_addr <= `DM_RST_CFG;
         q.kind <= dm_window_pkg::KIND_NONE;
         q.af_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // --------------------------------------------------------------------
   // link outputs
   // --------------------------------------------------------------------
   assign link.reg_rdata = q.rdata;
   assign link.reg_ack = q.ack;
   assign link.dm_hit = q.active;
   assign link.dm_kind = q.kind;
   assign link.pci_addr = q.pci_addr;
   assign link.lock_active = q.lock;
   assign link.write_fifo_almost_full_n = q.af_n;

   // --------------------------------------------------------------------
   // PCI read controls
   // --------------------------------------------------------------------
   assign pci_prefetch_o = q.active && !q.is_write && !rd_fifo_full_i
                           && (!q.ctl[`DM_CTL_PREF_LIMIT]
                               || (q.fetched != `DM_PREFETCH_LIMIT));
   assign pci_release_o = q.active && !q.is_write && rd_fifo_full_i
                          && !q.ctl[`DM_CTL_HOLD_ON_FULL];
   assign pci_irdy_n_o = !(q.active && !q.is_write && !rd_fifo_full_i);
endmodule

// *** verilog/dm_link_if.sv ***
// link between the local bus master and the direct-master window bridge
`timescale 1ns/1ps
interface dm_link_if;
   // register access
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_ack;
   // direct-master access
   logic acc_valid;
   logic acc_io;
   logic acc_write;
   logic acc_lock;
   logic [31:0] acc_addr;
   logic acc_done;
   // decode result
   logic dm_hit;
   dm_window_pkg::dm_kind_t dm_kind;
   logic [31:0] pci_addr;
   logic lock_active;
   logic write_fifo_almost_full_n;

   modport bridge (
      input reg_wr, reg_rd, reg_addr, reg_wdata, acc_valid, acc_io, acc_write, acc_lock,
      input acc_addr, acc_done,
      output reg_rdata, reg_ack, dm_hit, dm_kind, pci_addr, lock_active,
      output write_fifo_almost_full_n
   );
   modport master (
      output reg_wr, reg_rd, reg_addr, reg_wdata, acc_valid, acc_io, acc_write, acc_lock,
      output acc_addr, acc_done,
      input reg_rdata, reg_ack, dm_hit, dm_kind, pci_addr, lock_active,
      input write_fifo_almost_full_n
   );
endinterface

// *** verilog/dm_master_end.sv ***
// local master end: programs the window registers and issues direct-master accesses
`timescale 1ns/1ps
`include "dm_window_map.svh"
module dm_master_end #(
   parameter bit PLATFORM_FORCE = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link to bridge
   dm_link_if.master link,
   // user commands
   input wire logic cmd_valid_i,
   input wire logic [1:0] cmd_op_i, // 0 reg write, 1 reg read, 2 access
   input wire logic [31:0] cmd_addr_i,
   input wire logic [31:0] cmd_data_i,
   input wire logic cmd_io_i,
   input wire logic cmd_write_i,
   input wire logic cmd_lock_i,
   input wire logic [3:0] cmd_len_i,
   input wire logic acc_end_i,
   output logic cmd_ready_o,
   // user responses
   output logic rsp_valid_o,
   output logic rsp_refused_o,
   output logic [31:0] rsp_data_o
);
   dm_window_pkg::master_state_t q, d;
   logic [31:0] wdata;
   logic ok_acc, ok_wr;

   // --------------------------------------------------------------------
   // write value and ordering checks
   // --------------------------------------------------------------------
   always_comb begin
      wdata = cmd_data_i;
      if (PLATFORM_FORCE && cmd_addr_i[7:0] == `DM_OFS_REMAP_CTL) begin
         wdata[`DM_CTL_LOCK_EN] = 1'b1;
         wdata[`DM_CTL_PREF_LIMIT] = 1'b0;
         wdata[`DM_CTL_THR_MSB:`DM_CTL_THR_LSB] = 3'h0;
      end
   end
   assign ok_acc = q.range_set && q.ctl_set && (cmd_io_i ? q.io_set : q.mem_set)
                   && !(q.limit && cmd_len_i > `DM_MAX_LIMITED_BURST);
   assign ok_wr = !((cmd_addr_i[7:0] == `DM_OFS_MEM_BASE && q.io_set
                     && wdata[31:16] == q.io_base)
                    || (cmd_addr_i[7:0] == `DM_OFS_IO_BASE && q.mem_set
                        && wdata[31:16] == q.mem_base));

   // --------------------------------------------------------------------
   // sequencer
   // --------------------------------------------------------------------
   always_comb begin
      d = q;
      d.reg_wr = 1'b0;
      d.reg_rd = 1'b0;
      d.acc_valid = 1'b0;
      d.acc_done = 1'b0;
      d.rsp_valid = 1'b0;
      d.rsp_refused = 1'b0;
      case (q.fsm)
         dm_window_pkg::M_IDLE: begin
            if (cmd_valid_i) begin
               if (cmd_op_i == 2'h2 && ok_acc) begin
                  d.acc_valid = 1'b1;
                  d.acc_io = cmd_io_i;
                  d.acc_write = cmd_write_i;
                  d.acc_lock = cmd_lock_i;
                  d.acc_addr = cmd_addr_i;
                  d.fsm = dm_window_pkg::M_ACC;
               end else if (cmd_op_i == 2'h0 && ok_wr) begin
                  d.reg_wr = 1'b1;
                  d.reg_addr = cmd_addr_i[7:0];
                  d.reg_wdata = wdata;
                  d.fsm = dm_window_pkg::M_REG;
                  case (cmd_addr_i[7:0])
                     `DM_OFS_RANGE_MASK: d.range_set = 1'b1;
                     `DM_OFS_REMAP_CTL: begin
                        d.ctl_set = 1'b1;
                        d.limit = wdata[`DM_CTL_PREF_LIMIT];
                     end
                     `DM_OFS_MEM_BASE: begin
                        d.mem_set = 1'b1;
                        d.mem_base = wdata[31:16];
                     end
                     `DM_OFS_IO_BASE: begin
                        d.io_set = 1'b1;
                        d.io_base = wdata[31:16];
                     end
                     default: d.range_set = q.range_set;
                  endcase
               end else if (cmd_op_i == 2'h1) begin
                  d.reg_rd = 1'b1;
                  d.reg_addr = cmd_addr_i[7:0];
                  d.fsm = dm_window_pkg::M_REG;
               end else begin
                  d.rsp_valid = 1'b1;
                  d.rsp_refused = 1'b1;
               end
            end
         end
         dm_window_pkg::M_REG: begin
            if (link.reg_ack) begin
               d.rsp_valid = 1'b1;
               d.rsp_data = link.reg_rdata;
               d.fsm = dm_window_pkg::M_IDLE;
            end
         end
         dm_window_pkg::M_ACC: begin
            if (acc_end_i) begin
               d.acc_done = 1'b1;
               d.rsp_valid = 1'b1;
               d.rsp_refused = !link.dm_hit;
               d.rsp_data = link.pci_addr;
               d.fsm = dm_window_pkg::M_IDLE;
            end
         end
         default: d.fsm = dm_window_pkg::M_IDLE;
      endcase
      d.busy = (d.fsm != dm_window_pkg::M_IDLE);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.fsm <= dm_window_pkg::M_IDLE;
      end else begin
         q <= d;
      end
   end

   // --------------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------------
   assign link.reg_wr = q.reg_wr;
   assign link.reg_rd = q.reg_rd;
   assign link.reg_addr = q.reg_addr;
   assign link.reg_wdata = q.reg_wdata;
   assign link.acc_valid = q.acc_valid;
   assign link.acc_io = q.acc_io;
   assign link.acc_write = q.acc_write;
   assign link.acc_lock = q.acc_lock;
   assign link.acc_addr = q.acc_addr;
   assign link.acc_done = q.acc_done;
   assign cmd_ready_o = !q.busy;
   assign rsp_valid_o = q.rsp_valid;
   assign rsp_refused_o = q.rsp_refused;
   assign rsp_data_o = q.rsp_data;
endmodule

// *** verilog/dm_window_decode.sv ***
// one address window: masked compare against a base and upper-bit remap
`timescale 1ns/1ps
module dm_window_decode #(
   parameter int W = 16
) (
   // window settings
   input wire logic enable_i,
   input wire logic [W-1:0] mask_i,
   input wire logic [W-1:0] base_i,
   input wire logic [W-1:0] remap_i,
   // address
   input wire logic [W-1:0] addr_hi_i,
   output logic hit_o,
   output logic [W-1:0] mapped_hi_o
);
   // --------------------------------------------------------------------
   // compare only selected bits, replace selected bits with remap
   // --------------------------------------------------------------------
   assign hit_o = enable_i && (((addr_hi_i ^ base_i) & mask_i) == '0);
   assign mapped_hi_o = (addr_hi_i & ~mask_i) | (remap_i & mask_i);
endmodule

// *** verilog/dm_window_map.svh ***
// register offsets, field positions and reset values of the direct-master window block
`ifndef DM_WINDOW_MAP_SVH
`define DM_WINDOW_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (local configuration space, byte addresses)
// ----------------------------------------------------------------------
`define DM_OFS_RANGE_MASK 8'h9C
`define DM_OFS_MEM_BASE 8'hA0
`define DM_OFS_IO_BASE 8'hA4
`define DM_OFS_REMAP_CTL 8'hA8
`define DM_OFS_CFG_ADDR 8'hAC

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DM_HI_MSB 31
`define DM_HI_LSB 16
`define DM_CTL_MEM_EN 0
`define DM_CTL_IO_EN 1
`define DM_CTL_LOCK_EN 2
`define DM_CTL_PREF_LIMIT 3
`define DM_CTL_HOLD_ON_FULL 4
`define DM_CTL_THR_MSB 7
`define DM_CTL_THR_LSB 5
`define DM_CFG_TYPE_MSB 1
`define DM_CFG_REG_LSB 2
`define DM_CFG_BUS_MSB 23
`define DM_CFG_ENABLE 31

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define DM_RST_HI 16'h0000
`define DM_RST_CTL 8'h00
`define DM_RST_CFG 32'h0000_0000
`define DM_PREFETCH_LIMIT 3'h4
`define DM_WFIFO_DEPTH 4'h8
`define DM_MAX_LIMITED_BURST 4'h4

`endif

// *** verilog/dm_window_pkg.sv ***
// types shared by both ends of the direct-master window link
package dm_window_pkg;

   // ----------------------------------------------------------------------
   // kind of PCI cycle produced for a decoded local access
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      KIND_NONE = 2'h0,
      KIND_MEM = 2'h1,
      KIND_IO = 2'h3,
      KIND_CFG = 2'h2
   } dm_kind_t;

   // ----------------------------------------------------------------------
   // bridge end state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] range_mask;
      logic [15:0] mem_base;
      logic [15:0] io_base;
      logic [15:0] remap_hi;
      logic [7:0] ctl;
      logic [31:0] cfg_addr;
      logic [31:0] rdata;
      logic ack;
      logic active;
      logic is_write;
      logic lock;
      dm_kind_t kind;
      logic [31:0] pci_addr;
      logic [3:0] wcount;
      logic [2:0] fetched;
      logic af_n;
   } bridge_state_t;

   // ----------------------------------------------------------------------
   // master end sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      M_IDLE = 2'h0,
      M_REG = 2'h1,
      M_ACC = 2'h3
   } master_fsm_t;

   typedef struct packed {
      master_fsm_t fsm;
      logic range_set;
      logic ctl_set;
      logic mem_set;
      logic io_set;
      logic limit;
      logic [15:0] mem_base;
      logic [15:0] io_base;
      logic reg_wr;
      logic reg_rd;
      logic [7:0] reg_addr;
      logic [31:0] reg_wdata;
      logic acc_valid;
      logic acc_io;
      logic acc_write;
      logic acc_lock;
      logic [31:0] acc_addr;
      logic acc_done;
      logic busy;
      logic rsp_valid;
      logic rsp_refused;
      logic [31:0] rsp_data;
   } master_state_t;

endpackage
